//--- hdl/count_cell.sv
// constants package and one up-counting cell of the dual timer/counter
// assumes a single 50 MHz clock and an asynchronous active-high reset

package tmr_pkg;
    // register map, byte-wide registers on a 4-bit address
    localparam int         ADDR_W    = 4;
    localparam logic [3:0] A_CTRL0   = 4'h0;
    localparam logic [3:0] A_CTRL1   = 4'h1;
    localparam logic [3:0] A_MATCH0  = 4'h2;
    localparam logic [3:0] A_MATCH1  = 4'h3;
    localparam logic [3:0] A_DUTY0   = 4'h4;
    localparam logic [3:0] A_DUTY1   = 4'h5;
    localparam logic [3:0] A_SYS     = 4'h6;
    localparam logic [3:0] A_CNT0    = 4'h7;
    localparam logic [3:0] A_CNT1    = 4'h8;
    localparam logic [3:0] A_STAT    = 4'h9;
    // counter_control_reg fields
    localparam int         F_INIT    = 7;
    localparam int         F_SEL     = 4;
    localparam int         F_RUN     = 3;
    localparam int         F_MODE    = 0;
    // system register fields
    localparam int         F_DSS     = 0;
    localparam int         F_PWR     = 1;
    // reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] MATCH_RST = 8'hFF;
    localparam logic [7:0] DUTY_RST  = 8'h80;
    localparam logic [2:0] SYS_RST   = 3'h0;
    // clocks and prescaler
    localparam int         FC_HZ     = 50000000;
    localparam int         FS_HZ     = 32768;
    localparam int         FS_DIV    = FC_HZ / FS_HZ;
    localparam int         PRE_W     = 11;
    localparam int         FS8_W     = 3;

    typedef enum logic [2:0] {
        M_TMR  = 3'b000,
        M_PDO  = 3'b001,
        M_PWM  = 3'b010,
        M_RSV  = 3'b011,
        M_T16  = 3'b100,
        M_WARM = 3'b101,
        M_P16  = 3'b110,
        M_PPG  = 3'b111
    } mode_t;

    typedef enum logic [2:0] {
        S_SLOW = 3'b000,
        S_D7   = 3'b001,
        S_D5   = 3'b010,
        S_D3   = 3'b011,
        S_FS   = 3'b100,
        S_D1   = 3'b101,
        S_FC   = 3'b110,
        S_PIN  = 3'b111
    } sel_t;

    typedef enum logic [1:0] {
        P_RUN    = 2'b00,
        P_IDLE   = 2'b01,
        P_LRUN   = 2'b10,
        P_LSLEEP = 2'b11
    } pwr_t;
endpackage

`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module count_cell #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // control
    input  wire logic         run_in,
    input  wire logic         tick_in,
    input  wire logic         wrap_in,
    input  wire logic         clear_in,
    input  wire logic [W-1:0] cmp_in,
    // state
    output logic      [W-1:0] count_out,
    output logic              hit_out,
    output logic              ovf_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] nxt;

    // full-width compare of the value the tick is about to produce
    assign nxt       = cnt_q + 1'b1;
    assign hit_out   = tick_in && (nxt == cmp_in);
    assign ovf_out   = tick_in && (&cnt_q);
    assign count_out = cnt_q;

    // stop clears; a match clears only when wrapping is asked for
    assign cnt_d = (!run_in || clear_in) ? '0 :
                   !tick_in ? cnt_q :
                   (wrap_in && hit_out) ? '0 : nxt;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // count_cell

`default_nettype wire

//--- hdl/dual_timer.sv
// dual 8-bit timer/counter, chainable into one 16-bit counter
// assumes synchronous count pins and a byte-wide register port
`timescale 1ns/100ps
`default_nettype none

module dual_timer #(
    parameter int FS_DIV = tmr_pkg::FS_DIV
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // event count pins
    input  wire logic [1:0] count_pin_in,
    // events and pins
    output logic      [1:0] counter_match_irq_out,
    output logic      [1:0] divider_out_pin_out,
    output logic      [1:0] pwm_out_pin_out
);
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////
    // low-power source check, used for both channels
    function automatic logic src_ok(input logic [2:0] md,
                                    input logic [2:0] sel,
                                    input logic       low);
        logic ok;
        ok = 1'b1;
        if (low) begin
            case (md)
                tmr_pkg::M_TMR:  ok = (sel == tmr_pkg::S_SLOW) || (sel == tmr_pkg::S_PIN);
                tmr_pkg::M_PDO:  ok = (sel == tmr_pkg::S_SLOW);
                tmr_pkg::M_PWM:  ok = (sel == tmr_pkg::S_SLOW) || (sel == tmr_pkg::S_FS);
                tmr_pkg::M_T16:  ok = (sel == tmr_pkg::S_SLOW) || (sel == tmr_pkg::S_PIN);
                tmr_pkg::M_WARM: ok = (sel == tmr_pkg::S_FC);
                tmr_pkg::M_P16:  ok = (sel != tmr_pkg::S_D7) && (sel != tmr_pkg::S_D5)
                                      && (sel != tmr_pkg::S_D3) && (sel != tmr_pkg::S_D1)
                                      && (sel != tmr_pkg::S_FC);
                default:         ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and prescaler state
    logic [7:0]                  ctrl_q [2];
    logic [7:0]                  match_q [2];
    logic [7:0]                  dutyw_q [2];
    logic [7:0]                  duty_q [2];
    logic [2:0]                  sys_q;
    logic [tmr_pkg::PRE_W-1:0]   pre_q;
    logic [15:0]                 fs_cnt_q;
    logic [tmr_pkg::FS8_W-1:0]   fs8_q;
    logic [1:0]                  pin_q;
    logic [1:0]                  fl_q;
    logic [1:0]                  irq_q;
    logic [1:0]                  div_q;
    logic [1:0]                  pwm_q;
    logic [7:0]                  rd_q;

    // decoded control
    logic [2:0]  mode   [2];
    logic [2:0]  sel    [2];
    logic [2:0]  md_src [2];
    logic [7:0]  tv     [2];
    logic [7:0]  cnt    [2];
    logic [1:0]  run, tick, wrap, clr, hit, ovf, dhit;
    logic [1:0]  tog, irq_d, ld, fl_d, reload, pdo_en, pwm_en;
    logic [1:0]  wr_ctrl, wr_match, wr_duty, fall;
    logic        casc, low, dss, slow;
    logic        fc2, fc8, fc32, fc128, fc2048, fs_tick, fs8_tick;
    logic [15:0] comb, comb_p1;
    logic        comb_hit, comb_dhit, comb_ovf, t16_mode;
    logic [7:0]  rmux;

    ////////////////////////////////////////////////////////////////////////////
    // system bits and chaining
    assign dss  = sys_q[tmr_pkg::F_DSS];
    assign low  = sys_q[tmr_pkg::F_PWR+1]; // low-speed run and sleep states
    assign casc = (mode[0] == tmr_pkg::M_RSV) && mode[1][2];

    // prescaler taps: one-cycle enables off the fast clock
    assign fc2      = pre_q[0];
    assign fc8      = &pre_q[2:0];
    assign fc32     = &pre_q[4:0];
    assign fc128    = &pre_q[6:0];
    assign fc2048   = &pre_q;
    assign fs_tick  = (fs_cnt_q == 16'(FS_DIV - 1));
    assign fs8_tick = fs_tick && (&fs8_q);
    // slow states lose the fast divider, so only slow/8 is left there
    assign slow     = (dss || low) ? fs8_tick : fc2048;
    assign fall     = pin_q & ~count_pin_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q    <= '0;
            fs_cnt_q <= '0;
            fs8_q    <= '0;
            pin_q    <= 2'h3;
        end else begin
            pre_q    <= pre_q + 1'b1;
            fs_cnt_q <= fs_tick ? 16'h0000 : fs_cnt_q + 16'h0001;
            fs8_q    <= fs_tick ? fs8_q + 1'b1 : fs8_q;
            pin_q    <= count_pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel decode, registers and counter cells
    genvar j;
    generate
        for (j = 0; j < 2; j++) begin : g_ch
            assign mode[j]     = ctrl_q[j][tmr_pkg::F_MODE +: 3];
            assign sel[j]      = ctrl_q[j][tmr_pkg::F_SEL +: 3];
            assign wr_ctrl[j]  = wr_in && (addr_in == (j ? tmr_pkg::A_CTRL1 : tmr_pkg::A_CTRL0));
            assign wr_match[j] = wr_in && (addr_in == (j ? tmr_pkg::A_MATCH1 : tmr_pkg::A_MATCH0));
            assign wr_duty[j]  = wr_in && (addr_in == (j ? tmr_pkg::A_DUTY1 : tmr_pkg::A_DUTY0));
            // source vector is indexed by the clock select code
            assign tv[j] = {fall[j], 1'b1, fc2, fs_tick, fc8, fc32, fc128, slow};
            // a stopped channel reloads its duty at once
            assign reload[j] = !run[j] || irq_d[j] || (casc && irq_d[1]);
            // flop takes the init bit on any control write made while stopped
            assign ld[j]     = wr_ctrl[j] && !ctrl_q[j][tmr_pkg::F_RUN];
            assign fl_d[j]   = ld[j] ? wdata_in[tmr_pkg::F_INIT] : fl_q[j] ^ tog[j];

            count_cell #(.W(8)) u_cell (
                .clk_in    (clk_in),
                .rst_in    (rst_in),
                .run_in    (run[j]),
                .tick_in   (tick[j]),
                .wrap_in   (wrap[j]),
                .clear_in  (clr[j]),
                .cmp_in    (match_q[j]),
                .count_out (cnt[j]),
                .hit_out   (hit[j]),
                .ovf_out   (ovf[j])
            );

            // register writes; the match register has no buffer stage
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    ctrl_q[j]  <= tmr_pkg::CTRL_RST;
                    match_q[j] <= tmr_pkg::MATCH_RST;
                    dutyw_q[j] <= tmr_pkg::DUTY_RST;
                    duty_q[j]  <= tmr_pkg::DUTY_RST;
                end else begin
                    if (wr_ctrl[j])
                        ctrl_q[j] <= wdata_in;
                    if (wr_match[j])
                        match_q[j] <= wdata_in;
                    if (wr_duty[j])
                        dutyw_q[j] <= wdata_in;
                    if (reload[j])
                        duty_q[j] <= dutyw_q[j];
                end
            end

            // output flop, pins and match event, all registered
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    fl_q[j]  <= 1'b0;
                    irq_q[j] <= 1'b0;
                    div_q[j] <= 1'b1;
                    pwm_q[j] <= 1'b1;
                end else begin
                    fl_q[j]  <= fl_d[j];
                    irq_q[j] <= irq_d[j];
                    div_q[j] <= pdo_en[j] ? ~fl_d[j] : 1'b1;
                    pwm_q[j] <= pwm_en[j] ? ~fl_d[j] : 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // run, source and tick; chained upper runs off the lower overflow
    assign run[1]    = ctrl_q[1][tmr_pkg::F_RUN];
    assign run[0]    = casc ? run[1] : ctrl_q[0][tmr_pkg::F_RUN];
    assign md_src[0] = casc ? mode[1] : mode[0];
    assign md_src[1] = mode[1];
    assign tick[0]   = run[0] && (casc || mode[0] != tmr_pkg::M_RSV)
                       && tv[0][sel[0]] && src_ok(md_src[0], sel[0], low);
    assign tick[1]   = casc ? ovf[0]
                            : run[1] && !mode[1][2] && (mode[1] != tmr_pkg::M_RSV)
                              && tv[1][sel[1]] && src_ok(md_src[1], sel[1], low);

    // 8-bit timer, event and divider modes wrap at the match
    assign wrap[0] = !casc && (mode[0] == tmr_pkg::M_TMR || mode[0] == tmr_pkg::M_PDO);
    assign wrap[1] = !casc && (mode[1] == tmr_pkg::M_TMR || mode[1] == tmr_pkg::M_PDO);
    assign dhit[0] = tick[0] && (cnt[0] + 8'h01 == duty_q[0]);
    assign dhit[1] = tick[1] && (cnt[1] + 8'h01 == duty_q[1]);

    // chained compare on the 16-bit value the lower tick produces
    assign comb      = {cnt[1], cnt[0]};
    assign comb_p1   = comb + 16'h0001;
    assign t16_mode  = (mode[1] == tmr_pkg::M_T16) || (mode[1] == tmr_pkg::M_WARM);
    assign comb_hit  = tick[0] && (comb_p1 == {match_q[1], match_q[0]});
    assign comb_dhit = tick[0] && (comb_p1 == {duty_q[1], duty_q[0]});
    assign comb_ovf  = tick[0] && (&comb);
    assign clr[0]    = casc && t16_mode && comb_hit;
    assign clr[1]    = clr[0];

    // flop toggles: divider on match, PWM on duty match and overflow
    assign tog[0] = !casc && ((mode[0] == tmr_pkg::M_PDO && hit[0])
                  || (mode[0] == tmr_pkg::M_PWM && (dhit[0] || ovf[0])));
    assign tog[1] = casc ? (mode[1] == tmr_pkg::M_P16 && (comb_dhit || comb_ovf))
                  : ((mode[1] == tmr_pkg::M_PDO && hit[1])
                  || (mode[1] == tmr_pkg::M_PWM && (dhit[1] || ovf[1])));

    // match events; a chained pair reports on the upper channel only
    assign irq_d[0] = !casc && (wrap[0] ? hit[0] : mode[0] == tmr_pkg::M_PWM && ovf[0]);
    assign irq_d[1] = casc ? (t16_mode ? comb_hit : mode[1] == tmr_pkg::M_P16 && comb_ovf)
                    : (wrap[1] ? hit[1] : mode[1] == tmr_pkg::M_PWM && ovf[1]);
    assign pdo_en[0] = !casc && mode[0] == tmr_pkg::M_PDO;
    assign pdo_en[1] = !casc && mode[1] == tmr_pkg::M_PDO;
    assign pwm_en[0] = !casc && mode[0] == tmr_pkg::M_PWM;
    assign pwm_en[1] = casc ? mode[1] == tmr_pkg::M_P16 : mode[1] == tmr_pkg::M_PWM;

    ////////////////////////////////////////////////////////////////////////////
    // system register and read port; data valid only the cycle after
    always_comb begin
        case (addr_in)
            tmr_pkg::A_CTRL0:  rmux = ctrl_q[0];
            tmr_pkg::A_CTRL1:  rmux = ctrl_q[1];
            tmr_pkg::A_MATCH0: rmux = match_q[0];
            tmr_pkg::A_MATCH1: rmux = match_q[1];
            tmr_pkg::A_DUTY0:  rmux = duty_q[0]; // active value, not the pending one
            tmr_pkg::A_DUTY1:  rmux = duty_q[1];
            tmr_pkg::A_SYS:    rmux = {5'h00, sys_q};
            tmr_pkg::A_CNT0:   rmux = cnt[0];
            tmr_pkg::A_CNT1:   rmux = cnt[1];
            tmr_pkg::A_STAT:   rmux = {5'h00, casc, fl_q};
            default:           rmux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sys_q <= tmr_pkg::SYS_RST;
            rd_q  <= 8'h00;
        end else begin
            if (wr_in && addr_in == tmr_pkg::A_SYS)
                sys_q <= wdata_in[2:0];
            rd_q <= rd_in ? rmux : 8'h00;
        end
    end

    assign rdata_out             = rd_q;
    assign counter_match_irq_out = irq_q;
    assign divider_out_pin_out   = div_q;
    assign pwm_out_pin_out       = pwm_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_timer_match_clr : assert property (
        (tick[0] && wrap[0] && cnt[0] + 8'h01 == match_q[0])
        |=> counter_match_irq_out[0] && cnt[0] == 8'h00)
        else $error("lower match did not raise event and clear");

    a_timer_restart : assert property (
        counter_match_irq_out[0] && run[0] && tick[0] && wrap[0] && match_q[0] != 8'h01
        |=> cnt[0] == 8'h01)
        else $error("counter did not resume from zero");

    // match writes are legal only while stopped, so watch the compare operand itself
    a_match_unbuffered : assert property (
        wr_match[0] |=> match_q[0] == $past(wdata_in))
        else $error("new match value not used at next compare");

    a_upper_on_ovf : assert property (
        casc && !ovf[0] && !clr[1] && run[1] |=> $stable(cnt[1]))
        else $error("chained upper moved without lower overflow");

    a_reserved_idle : assert property (
        mode[0] == tmr_pkg::M_RSV && !mode[1][2] [*2] |-> !counter_match_irq_out[0])
        else $error("reserved mode produced an event");

    a_low_src_limit : assert property (
        low && md_src[0] == tmr_pkg::M_PDO && sel[0] != tmr_pkg::S_SLOW |-> !tick[0])
        else $error("forbidden source ticked in low-power state");

    a_slow_source : assert property (
        !low && !dss && tick[0] && sel[0] == tmr_pkg::S_SLOW && !casc
        && mode[0] != tmr_pkg::M_RSV |-> pre_q == '1)
        else $error("slowest source not fast clock over 2048");

    a_width_wrap : assert property (
        cnt[0] == 8'hFF && tick[0] && !wrap[0] && !clr[0] |=> cnt[0] == 8'h00)
        else $error("counter not eight bits wide");

    a_pdo_toggle : assert property (
        pdo_en[0] && hit[0] && !ld[0] ##1 pdo_en[0] |-> div_q[0] != $past(div_q[0]))
        else $error("divider pin did not toggle on match");

    a_chain_match : assert property (
        casc && t16_mode && comb_hit
        |=> counter_match_irq_out[1] && cnt[0] == 8'h00 && cnt[1] == 8'h00)
        else $error("16-bit match did not clear and signal");

    c_timer_event : cover property (counter_match_irq_out[0] && wrap[0]);
    c_chain_event : cover property (casc && counter_match_irq_out[1]);
    c_pwm_toggle  : cover property (pwm_en[0] && tog[0] ##1 pwm_en[0]);
    c_low_tick    : cover property (low && tick[0]);
endmodule // dual_timer

`default_nettype wire

//--- testbench/test_dual_timer.sv
// self-checking bench for the dual timer/counter, one task per scenario
// assumes tmr_pkg and the design are compiled first; FS_DIV is shortened to 4
`timescale 1ns/100ps
`default_nettype none

module test_dual_timer;
    localparam int FSD = 4;

    logic            clk_in       = 1'b0;
    logic            rst_in       = 1'b1;
    logic      [3:0] addr_in      = 4'h0;
    logic      [7:0] wdata_in     = 8'h00;
    logic            wr_in        = 1'b0;
    logic            rd_in        = 1'b0;
    logic      [1:0] count_pin_in = 2'h3;
    wire logic [7:0] rdata_out;
    wire logic [1:0] irq;
    wire logic [1:0] div_pin;
    wire logic [1:0] pwm_pin;
    int              n_mismatch   = 0;
    int              cmp_count    = 0;

    dual_timer #(.FS_DIV(FSD)) dut (
        .clk_in                (clk_in),
        .rst_in                (rst_in),
        .addr_in               (addr_in),
        .wdata_in              (wdata_in),
        .wr_in                 (wr_in),
        .rd_in                 (rd_in),
        .rdata_out             (rdata_out),
        .count_pin_in          (count_pin_in),
        .counter_match_irq_out (irq),
        .divider_out_pin_out   (div_pin),
        .pwm_out_pin_out       (pwm_pin)
    );

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////
    // shared helpers

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle write; the idle cycle before it keeps strobes from being re-driven
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        chk(nm, {8'h00, exp}, {8'h00, rdata_out});
    endtask

    // cycles between two match pulses of one channel, bounded by lim
    task automatic gap(input int ch, input int lim, output int n);
        int k;
        k = 0;
        while (irq[ch] !== 1'b1 && k < lim) begin
            @(negedge clk_in);
            k++;
        end
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (irq[ch] !== 1'b1 && n < lim);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios

    task automatic s_reset;
        @(negedge clk_in);
        chk("pins idle", 16'h000F, {12'h000, div_pin, pwm_pin});
        chk("irq idle", 16'h0000, {14'h0000, irq});
        rd(tmr_pkg::A_CTRL0, 8'h00, "ctrl0");
        rd(tmr_pkg::A_CTRL1, 8'h00, "ctrl1");
        rd(tmr_pkg::A_MATCH0, 8'hFF, "match0");
        rd(tmr_pkg::A_DUTY1, 8'h80, "duty1");
        rd(tmr_pkg::A_SYS, 8'h00, "sys");
        wr(tmr_pkg::A_CNT0, 8'h55);
        rd(tmr_pkg::A_CNT0, 8'h00, "count0 read-only");
        rd(4'hF, 8'h00, "unmapped");
    endtask

    // stop writes repeat mode, select and init bit, as every control write replaces all of them
    task automatic s_timer;
        int n;
        wr(tmr_pkg::A_MATCH0, 8'h03);
        wr(tmr_pkg::A_CTRL0, 8'h68);
        gap(0, 300, n);
        chk("timer period", 16'd3, n[15:0]);
        gap(0, 300, n);
        chk("timer restart", 16'd3, n[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h60);
        wr(tmr_pkg::A_MATCH0, 8'hFF);
        wr(tmr_pkg::A_CTRL0, 8'h68);
        gap(0, 600, n);
        chk("full width period", 16'd255, n[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h60);
    endtask

    task automatic s_slowest;
        int n;
        wr(tmr_pkg::A_MATCH0, 8'h01);
        wr(tmr_pkg::A_CTRL0, 8'h08);
        gap(0, 5000, n);
        chk("fast/2048 period", 16'd2048, n[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h00);
        wr(tmr_pkg::A_SYS, 8'h01);
        wr(tmr_pkg::A_CTRL0, 8'h08);
        gap(0, 500, n);
        chk("slow/8 period", 16'(8 * FSD), n[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h00);
    endtask

    // in low-power states the fast clock must give divider mode no ticks at all
    task automatic s_low_power;
        int n;
        int seen;
        seen = 0;
        wr(tmr_pkg::A_SYS, 8'h04);
        wr(tmr_pkg::A_CTRL0, 8'h69);
        repeat (100) begin
            @(negedge clk_in);
            if (irq[0] !== 1'b0 || div_pin[0] !== 1'b1) seen++;
        end
        chk("blocked source events", 16'd0, seen[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h61);
        wr(tmr_pkg::A_CTRL0, 8'h08);
        gap(0, 500, n);
        chk("low power slowest", 16'(8 * FSD), n[15:0]);
        wr(tmr_pkg::A_CTRL0, 8'h00);
        wr(tmr_pkg::A_SYS, 8'h00);
    endtask

    // combined match 0102, duty 0080: in range for every 16-bit mode
    task automatic s_chain;
        int n;
        wr(tmr_pkg::A_MATCH0, 8'h02);
        wr(tmr_pkg::A_MATCH1, 8'h01);
        wr(tmr_pkg::A_DUTY0, 8'h80);
        wr(tmr_pkg::A_DUTY1, 8'h00);
        rd(tmr_pkg::A_DUTY1, 8'h00, "stopped duty reload");
        wr(tmr_pkg::A_CTRL0, 8'h63);
        wr(tmr_pkg::A_CTRL1, 8'h0C);
        gap(1, 1000, n);
        chk("chained period", 16'h0102, n[15:0]);
        wr(tmr_pkg::A_CTRL1, 8'h08);
        wr(tmr_pkg::A_CTRL1, 8'h0D);
        gap(1, 1000, n);
        chk("warm-up period", 16'h0102, n[15:0]);
        wr(tmr_pkg::A_CTRL1, 8'h05);
        wr(tmr_pkg::A_CTRL0, 8'h00);
    endtask

    // pin high right after the wrap, low from the duty match on
    task automatic s_pwm;
        int n;
        wr(tmr_pkg::A_DUTY0, 8'h80);
        wr(tmr_pkg::A_CTRL0, 8'h6A);
        gap(0, 600, n);
        chk("pwm period", 16'd256, n[15:0]);
        chk("pwm pin at wrap", 16'h0001, {15'h0000, pwm_pin[0]});
        repeat (128) @(negedge clk_in);
        chk("pwm pin at duty", 16'h0000, {15'h0000, pwm_pin[0]});
        wr(tmr_pkg::A_CTRL0, 8'h62);
    endtask

    // two falling edges on the lower pin reach a match of 2
    task automatic s_event;
        wr(tmr_pkg::A_MATCH0, 8'h02);
        wr(tmr_pkg::A_CTRL0, 8'h78);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_in);
            count_pin_in[0] <= 1'b0;
            @(posedge clk_in);
            count_pin_in[0] <= 1'b1;
            @(negedge clk_in);
            chk("event irq", 16'(k), {14'h0000, irq});
        end
        wr(tmr_pkg::A_CTRL0, 8'h70);
    endtask

    task automatic s_divider;
        int   n;
        logic p;
        for (int ch = 0; ch < 2; ch++) begin
            wr(ch ? tmr_pkg::A_MATCH1 : tmr_pkg::A_MATCH0, 8'h02);
            wr(ch ? tmr_pkg::A_CTRL1 : tmr_pkg::A_CTRL0, 8'h69);
            gap(ch, 300, n);
            chk("divider period", 16'd2, n[15:0]);
            p = div_pin[ch];
            repeat (2) @(negedge clk_in);
            chk("divider toggle", {15'h0000, ~p}, {15'h0000, div_pin[ch]});
            wr(ch ? tmr_pkg::A_CTRL1 : tmr_pkg::A_CTRL0, 8'h61);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict and run control

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // about 15000 cycles, some two and a half times what the scenarios need
    initial begin
        #300000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        s_reset();
        s_timer();
        s_slowest();
        s_low_power();
        s_chain();
        s_pwm();
        s_event();
        s_divider();
        test_done();
    end
endmodule // test_dual_timer

`default_nettype wire
